//--- rtl/qps_slave.v
// Two-wire slave, command decoder and wiper registers of the quad pot
// Notes on behaviour
// - Data changes only with clock low; changes with clock high mean start/stop.
// - Watch both lines always; ignore all activity until a start is seen.
// - After eight bits transmitter releases data; receiver pulls low on ninth clock.
// - Acknowledge the matching address, a valid instruction, and any following data byte.
// - Address byte follows start; its upper nibble is the device type.
// - Lower address nibble must equal all four address select pins.
// - Stop after a nonvolatile write starts it; address not acked until done.
// - Instruction: opcode upper nibble, then two pot bits, then two slot bits.
// - Four opcodes finish with the instruction byte, moving wiper/slot values.
// - Slot to wiper load is volatile; wiper output follows after a delay.
// - Wiper to slot copy is a nonvolatile write lasting the write time.
// - Wiper and slot reads/writes take three bytes, the third carries the value.
// - Increment mode: clock pulse with data high steps wiper toward high end.
// - Increment mode: clock pulse with data low steps wiper toward low end.
// - Low six wiper bits decode one-hot to one of 64 taps.
// - 63 segments and 64 taps; the position covers every tap.
// - Wipers and slots are read/writable; a wiper loads from any own slot.
// - Data pin is only pulled low or released, never driven high.
// - Wiper byte: bits 5..0 position, bit 7 cascade, bit 6 floats wiper.
// - Global transfers ignore pot bits and act on all four pots.
// - Every slot change is nonvolatile, lasting at most 10 ms.
// - At power-up each wiper loads from slot zero of its pot.
`include "qps_consts.vh"

module qps_slave #(
  // Arbitrary device type identifier
  parameter [3:0]               DEVICE_TYPE_ID  = 4'h9,
  parameter [`QPS_NV_CNT_W-1:0] NV_WRITE_CYCLES = `QPS_NV_WRITE_CYCLES
) (
  // Clocking
  input  wire         sys_clk_in,
  input  wire         rst_in,
  input  wire         ce_in,
  // Two-wire bus
  input  wire         scl_in,
  input  wire         sda_in,
  output wire         sda_out,
  output wire         sda_oe_out,
  // Straps
  input  wire [3:0]   address_select_pins_in,
  // Wiper outputs
  output reg  [255:0] tap_select_out,
  output reg  [3:0]   wiper_float_out,
  output reg  [3:0]   cascade_enable_out,
  // Status
  output wire         nv_busy_out,
  output wire         incdec_active_out
);
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_ADDR   = 3'h1;
  localparam [2:0] ST_INSTR  = 3'h2;
  localparam [2:0] ST_DATA   = 3'h3;
  localparam [2:0] ST_TX     = 3'h4;
  localparam [2:0] ST_INCDEC = 3'h5;
  localparam [2:0] ST_WAIT   = 3'h6;
  localparam [`QPS_WIPER_CNT_W-1:0] WIPER_DLY = `QPS_STOP_WIPER_CYCLES - 8'h01;

  // Synchronisers and edge history
  reg [1:0]   scl_sync_q;
  reg [1:0]   sda_sync_q;
  reg [7:0]   strap_sync_q;
  reg         scl_prev_q;
  reg         sda_prev_q;
  // Protocol state
  reg [2:0]   state_q;
  reg [2:0]   next_q;
  reg [3:0]   bit_q;
  reg         in_ack_q;
  reg [7:0]   shift_q;
  reg [7:0]   instr_q;
  reg [7:0]   tx_q;
  reg         sda_oe_q;
  // Volatile wipers and pending writes
  reg [7:0]   wcr_q [0:3];
  reg [7:0]   pend_val_q [0:3];
  reg [3:0]   pend_mask_q;
  reg [1:0]   pend_slot_q;
  reg         commit_q;
  reg         load_pend_q;
  reg         load_go_q;
  reg         boot_q;
  reg [`QPS_WIPER_CNT_W-1:0] dly_q;
  integer     i;

  wire         scl;
  wire         sda;
  wire         scl_rise;
  wire         scl_fall;
  wire         start_det;
  wire         stop_det;
  wire         busy;
  wire [127:0] slots;
  wire         store_busy;
  wire         fifo_in_ready;
  wire         fifo_in_valid;
  wire [11:0]  fifo_in_data;
  wire         fifo_out_valid;
  wire         fifo_out_ready;
  wire [11:0]  fifo_out_data;
  wire [1:0]   low_pot;
  wire [3:0]   opc;
  wire [1:0]   pot;
  wire [1:0]   slot;
  wire [1:0]   cur_pot;
  wire [5:0]   cur_pos;

  function [63:0] tap_decode;
    input [5:0] pos;
    begin
      tap_decode = 64'h1 << pos;
    end
  endfunction

  function [3:0] pot_onehot;
    input [1:0] p;
    begin
      pot_onehot = 4'h1 << p;
    end
  endfunction

  function [1:0] lowest_pot;
    input [3:0] m;
    begin
      lowest_pot = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
    end
  endfunction

  function [7:0] slot_of;
    input [127:0] s;
    input [1:0]   p;
    input [1:0]   r;
    begin
      slot_of = s[{p, r, 3'h0} +: 8];
    end
  endfunction

  assign scl       = scl_sync_q[1];
  assign sda       = sda_sync_q[1];
  assign scl_rise  = scl & ~scl_prev_q;
  assign scl_fall  = ~scl & scl_prev_q;
  assign start_det = scl & scl_prev_q & sda_prev_q & ~sda;
  assign stop_det  = scl & scl_prev_q & ~sda_prev_q & sda;
  assign busy      = commit_q | fifo_out_valid | store_busy;
  assign opc       = shift_q[`QPS_OPC_HI:`QPS_OPC_LO];
  assign pot       = shift_q[`QPS_POT_HI:`QPS_POT_LO];
  assign slot      = shift_q[`QPS_SLOT_HI:`QPS_SLOT_LO];
  assign cur_pot   = instr_q[`QPS_POT_HI:`QPS_POT_LO];
  assign cur_pos   = wcr_q[cur_pot][`QPS_POS_W-1:0];
  assign low_pot   = lowest_pot(pend_mask_q);

  assign sda_out           = 1'b0;
  assign sda_oe_out        = sda_oe_q;
  assign nv_busy_out       = busy;
  assign incdec_active_out = (state_q == ST_INCDEC);

  assign fifo_in_valid  = commit_q & (pend_mask_q != 4'h0);
  assign fifo_in_data   = {low_pot, pend_slot_q, pend_val_q[low_pot]};

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      scl_sync_q   <= 2'h3;
      sda_sync_q   <= 2'h3;
      strap_sync_q <= 8'h00;
      scl_prev_q   <= 1'b1;
      sda_prev_q   <= 1'b1;
    end else if (ce_in) begin
      scl_sync_q   <= {scl_sync_q[0], scl_in};
      sda_sync_q   <= {sda_sync_q[0], sda_in};
      strap_sync_q <= {strap_sync_q[3:0], address_select_pins_in};
      scl_prev_q   <= scl;
      sda_prev_q   <= sda;
    end
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_q     <= ST_IDLE;
      next_q      <= ST_WAIT;
      bit_q       <= 4'h0;
      in_ack_q    <= 1'b0;
      shift_q     <= 8'h00;
      instr_q     <= 8'h00;
      tx_q        <= 8'h00;
      sda_oe_q    <= 1'b0;
      pend_mask_q <= 4'h0;
      pend_slot_q <= 2'h0;
      commit_q    <= 1'b0;
      load_pend_q <= 1'b0;
      load_go_q   <= 1'b0;
      boot_q      <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        wcr_q[i]      <= `QPS_WPR_RESET;
        pend_val_q[i] <= 8'h00;
      end
    end else if (ce_in) begin
      load_go_q <= 1'b0;
      // Pending writes drain into the FIFO one per cycle; full FIFO stalls here
      if (commit_q) begin
        if (pend_mask_q == 4'h0)
          commit_q <= 1'b0;
        else if (fifo_in_ready)
          pend_mask_q <= pend_mask_q & ~pot_onehot(low_pot);
      end
      if (boot_q) begin
        boot_q <= 1'b0;
        for (i = 0; i < 4; i = i + 1)
          wcr_q[i] <= slot_of(slots, i[1:0], 2'h0);
      end else if (start_det) begin
        state_q  <= ST_ADDR;
        bit_q    <= 4'h0;
        in_ack_q <= 1'b0;
        sda_oe_q <= 1'b0;
        // An unfinished write with no stop is dropped
        if (!commit_q)
          pend_mask_q <= 4'h0;
      end else if (stop_det) begin
        state_q  <= ST_IDLE;
        bit_q    <= 4'h0;
        in_ack_q <= 1'b0;
        sda_oe_q <= 1'b0;
        if (pend_mask_q != 4'h0)
          commit_q <= 1'b1;
        load_go_q   <= load_pend_q;
        load_pend_q <= 1'b0;
      end else if (state_q != ST_IDLE && state_q != ST_WAIT) begin
        if (scl_rise) begin
          if (state_q == ST_INCDEC) begin
            if (sda && cur_pos != `QPS_POS_MAX)
              wcr_q[cur_pot][`QPS_POS_W-1:0] <= cur_pos + 6'h01;
            else if (!sda && cur_pos != 6'h00)
              wcr_q[cur_pot][`QPS_POS_W-1:0] <= cur_pos - 6'h01;
          end else if (!in_ack_q && bit_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda};
            bit_q   <= bit_q + 4'h1;
          end
        end
        if (scl_fall && state_q != ST_INCDEC) begin
          if (in_ack_q) begin
            in_ack_q <= 1'b0;
            bit_q    <= 4'h0;
            state_q  <= next_q;
            sda_oe_q <= (next_q == ST_TX) ? ~tx_q[7] : 1'b0;
          end else if (bit_q == 4'h8) begin
            sda_oe_q <= 1'b0;
            in_ack_q <= 1'b1;
            next_q   <= ST_WAIT;
            case (state_q)
              ST_ADDR: begin
                if (shift_q[7:4] == DEVICE_TYPE_ID && shift_q[3:0] == strap_sync_q[7:4]
                    && !busy) begin
                  sda_oe_q <= 1'b1;
                  next_q   <= ST_INSTR;
                end else begin
                  in_ack_q <= 1'b0;
                  state_q  <= ST_WAIT;
                end
              end
              ST_INSTR: begin
                instr_q  <= shift_q;
                sda_oe_q <= 1'b1;
                case (opc)
                  `QPS_OP_RD_WPR: begin
                    tx_q   <= wcr_q[pot];
                    next_q <= ST_TX;
                  end
                  `QPS_OP_RD_SLOT: begin
                    tx_q   <= slot_of(slots, pot, slot);
                    next_q <= ST_TX;
                  end
                  `QPS_OP_WR_WPR,
                  `QPS_OP_WR_SLOT: next_q <= ST_DATA;
                  `QPS_OP_SLOT_TO_WPR: begin
                    wcr_q[pot]  <= slot_of(slots, pot, slot);
                    load_pend_q <= 1'b1;
                  end
                  `QPS_OP_WPR_TO_SLOT: begin
                    pend_mask_q     <= pot_onehot(pot);
                    pend_slot_q     <= slot;
                    pend_val_q[pot] <= wcr_q[pot];
                  end
                  `QPS_OP_G_SLOT_TO_WPR: begin
                    for (i = 0; i < 4; i = i + 1)
                      wcr_q[i] <= slot_of(slots, i[1:0], slot);
                    load_pend_q <= 1'b1;
                  end
                  `QPS_OP_G_WPR_TO_SLOT: begin
                    pend_mask_q <= 4'hf;
                    pend_slot_q <= slot;
                    for (i = 0; i < 4; i = i + 1)
                      pend_val_q[i] <= wcr_q[i];
                  end
                  `QPS_OP_INCDEC: next_q <= ST_INCDEC;
                  default: begin
                    sda_oe_q <= 1'b0;
                    in_ack_q <= 1'b0;
                    state_q  <= ST_WAIT;
                  end
                endcase
              end
              ST_DATA: begin
                sda_oe_q <= 1'b1;
                if (instr_q[`QPS_OPC_HI:`QPS_OPC_LO] == `QPS_OP_WR_WPR) begin
                  wcr_q[cur_pot] <= shift_q;
                end else begin
                  pend_mask_q         <= pot_onehot(cur_pot);
                  pend_slot_q         <= instr_q[`QPS_SLOT_HI:`QPS_SLOT_LO];
                  pend_val_q[cur_pot] <= shift_q;
                end
              end
              default: begin
                // Transmit done; master's ack slot, device stays released
                sda_oe_q <= 1'b0;
              end
            endcase
          end else if (state_q == ST_TX && bit_q != 4'h0) begin
            tx_q     <= {tx_q[6:0], 1'b0};
            sda_oe_q <= ~tx_q[6];
          end
        end
      end
    end
  end

  // Wiper outputs hold during a pending load and for the stop-to-wiper delay
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      dly_q              <= {`QPS_WIPER_CNT_W{1'b0}};
      tap_select_out     <= {4{64'h1}};
      wiper_float_out    <= 4'h0;
      cascade_enable_out <= 4'h0;
    end else if (ce_in) begin
      if (load_go_q)
        dly_q <= WIPER_DLY;
      else if (dly_q != {`QPS_WIPER_CNT_W{1'b0}})
        dly_q <= dly_q - {{(`QPS_WIPER_CNT_W-1){1'b0}}, 1'b1};
      if (!load_pend_q && !load_go_q && dly_q == {`QPS_WIPER_CNT_W{1'b0}}) begin
        for (i = 0; i < 4; i = i + 1) begin
          tap_select_out[i*64 +: 64] <= tap_decode(wcr_q[i][`QPS_POS_W-1:0]);
          wiper_float_out[i]         <= wcr_q[i][`QPS_WIPER_FLOAT_BIT];
          cascade_enable_out[i]      <= wcr_q[i][`QPS_CASCADE_BIT];
        end
      end
    end
  end

  qps_fifo #(
    .WIDTH (`QPS_FIFO_WIDTH),
    .DEPTH (`QPS_FIFO_DEPTH),
    .AW    (`QPS_FIFO_AW)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data)
  );

  qps_nv_store #(
    .NV_WRITE_CYCLES (NV_WRITE_CYCLES)
  ) u_store (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .ce_in        (ce_in),
    .wr_valid_in  (fifo_out_valid),
    .wr_ready_out (fifo_out_ready),
    .wr_req_in    (fifo_out_data),
    .slots_out    (slots),
    .busy_out     (store_busy)
  );
endmodule

//--- rtl/qps_consts.vh
// Shared constants of the quad pot serial slave
`ifndef QPS_CONSTS_VH
`define QPS_CONSTS_VH

// Clock and timing
`define QPS_CLK_PERIOD_NS     5
`define QPS_NV_WRITE_NS       5000000
// Cycle counts at the 5 ns clock, sized to the counters that load them
`define QPS_NV_WRITE_CYCLES   24'hf4240
`define QPS_STOP_WIPER_NS     1000
`define QPS_STOP_WIPER_CYCLES 8'hc8
`define QPS_NV_CNT_W          24
`define QPS_WIPER_CNT_W       8

// Write request buffer: {pot[11:10], slot[9:8], value[7:0]}
`define QPS_FIFO_WIDTH        12
`define QPS_FIFO_DEPTH        16
`define QPS_FIFO_AW           4

// Instruction byte fields
`define QPS_OPC_HI            7
`define QPS_OPC_LO            4
`define QPS_POT_HI            3
`define QPS_POT_LO            2
`define QPS_SLOT_HI           1
`define QPS_SLOT_LO           0

// Opcodes
`define QPS_OP_RD_WPR         4'h9
`define QPS_OP_WR_WPR         4'ha
`define QPS_OP_RD_SLOT        4'hb
`define QPS_OP_WR_SLOT        4'hc
`define QPS_OP_SLOT_TO_WPR    4'hd
`define QPS_OP_WPR_TO_SLOT    4'he
`define QPS_OP_G_SLOT_TO_WPR  4'h1
`define QPS_OP_G_WPR_TO_SLOT  4'h8
`define QPS_OP_INCDEC         4'h2

// Wiper register layout and reset values
`define QPS_POS_W             6
`define QPS_POS_MAX           6'h3f
`define QPS_WIPER_FLOAT_BIT   6
`define QPS_CASCADE_BIT       7
`define QPS_WPR_RESET         8'h00
`define QPS_SLOT_RESET        8'h00

`endif

//--- rtl/qps_fifo.v
// Parameterised valid/ready FIFO for pending nonvolatile writes
`include "qps_consts.vh"

module qps_fifo #(
  parameter WIDTH = `QPS_FIFO_WIDTH,
  parameter DEPTH = `QPS_FIFO_DEPTH,
  parameter AW    = `QPS_FIFO_AW
) (
  // Clocking
  input  wire             sys_clk_in,
  input  wire             rst_in,
  input  wire             ce_in,
  // Fill side
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  // Drain side
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count_q != DEPTH[AW:0]);
  assign out_valid_out = (count_q != {(AW+1){1'b0}});
  assign out_data_out  = mem_q[rd_ptr_q];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else if (ce_in) begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data_in;
        wr_ptr_q        <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop)
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule

//--- rtl/qps_nv_store.v
// Nonvolatile data slots (4 pots x 4 slots) with timed write cycle
`include "qps_consts.vh"

module qps_nv_store #(
  parameter [`QPS_NV_CNT_W-1:0] NV_WRITE_CYCLES = `QPS_NV_WRITE_CYCLES
) (
  // Clocking
  input  wire         sys_clk_in,
  input  wire         rst_in,
  input  wire         ce_in,
  // Write requests
  input  wire         wr_valid_in,
  output wire         wr_ready_out,
  input  wire [11:0]  wr_req_in,
  // State
  output reg  [127:0] slots_out,
  output wire         busy_out
);
  reg                     busy_q;
  reg [`QPS_NV_CNT_W-1:0] cnt_q;
  reg [3:0]               idx_q;
  reg [7:0]               val_q;
  integer                 i;

  // Only one write cycle runs at a time; the FIFO ahead absorbs the rest
  assign wr_ready_out = ~busy_q;
  assign busy_out     = busy_q;

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      busy_q <= 1'b0;
      cnt_q  <= {`QPS_NV_CNT_W{1'b0}};
      idx_q  <= 4'h0;
      val_q  <= 8'h00;
      for (i = 0; i < 16; i = i + 1)
        slots_out[i*8 +: 8] <= `QPS_SLOT_RESET;
    end else if (ce_in) begin
      if (!busy_q && wr_valid_in) begin
        busy_q <= 1'b1;
        cnt_q  <= NV_WRITE_CYCLES - {{(`QPS_NV_CNT_W-1){1'b0}}, 1'b1};
        idx_q  <= wr_req_in[11:8];
        val_q  <= wr_req_in[7:0];
      end else if (busy_q) begin
        if (cnt_q == {`QPS_NV_CNT_W{1'b0}}) begin
          busy_q                      <= 1'b0;
          slots_out[{idx_q, 3'h0} +: 8] <= val_q;
        end else begin
          cnt_q <= cnt_q - {{(`QPS_NV_CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

//--- verification/qps_bus_master.sv
// Two-wire bus master model: drives the clock, pulls data low or releases it
module qps_bus_master (
  // Bus
  output logic scl_out,
  output logic sda_pull_out,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Whole-ns steps (31+31+31+32 = 125 ns a bit) keep pin changes off rising clock edges
  localparam int Q = 31;

  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task automatic start;
    #Q;
    sda_pull_out = 1'b1;
    #Q;
    scl_out = 1'b0;
    #Q;
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_pull_out = ~b;
    #Q;
    scl_out = 1'b1;
    #Q;
    s = sda_in;
    #Q;
    scl_out = 1'b0;
    #(Q + 1);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // read byte, master does not ack
  task automatic rbyte(output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    bit_io(1'b1, s);
  endtask
  task automatic stop;
    sda_pull_out = 1'b1;
    #Q;
    scl_out = 1'b1;
    #Q;
    sda_pull_out = 1'b0;
    #Q;
  endtask
endmodule

//--- verification/qps_slave_monitor.sv
// Concurrent checks on the quad pot serial slave ports
module qps_slave_monitor (
  // Clocking
  input wire logic         sys_clk_in,
  input wire logic         rst_in,
  // Bus
  input wire logic         scl_in,
  input wire logic         sda_in,
  input wire logic         sda_out,
  input wire logic         sda_oe_out,
  // Wiper and status
  input wire logic [255:0] tap_select_out,
  input wire logic [3:0]   wiper_float_out,
  input wire logic [3:0]   cascade_enable_out,
  input wire logic         nv_busy_out,
  input wire logic         incdec_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  AST_SDA_NEVER_HIGH: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  AST_RESET_STATE: assert property ($fell(rst_in) |-> tap_select_out == {4{64'h1}}
    && wiper_float_out == 4'h0 && cascade_enable_out == 4'h0 && !nv_busy_out)
    else $error("wrong state after reset");
  AST_TAP_ONE_HOT: assert property ($onehot(tap_select_out[63:0])
    && $onehot(tap_select_out[127:64]) && $onehot(tap_select_out[191:128])
    && $onehot(tap_select_out[255:192])) else $error("tap select not one-hot");
  // Pull-down may only move while the bus clock is low
  AST_OE_CHANGES_LOW: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data pull changed with clock high");
  AST_OE_AFTER_FALL: assert property ($rose(sda_oe_out) |-> $past(scl_in, 6)
    && !$past(scl_in, 1)) else $error("pull started away from a clock fall");
  AST_BUSY_NO_ACK: assert property (nv_busy_out |-> !sda_oe_out)
    else $error("acknowledge while write cycle runs");
  AST_STEP_SETTLED: assert property (incdec_active_out && !scl_in && !$past(scl_in, 8)
    |-> $stable(tap_select_out)) else $error("wiper moved without a clock pulse");
  AST_STOP_ENDS_STEP: assert property (incdec_active_out && scl_in && $rose(sda_in)
    |-> ##[1:8] !incdec_active_out) else $error("stepping mode outlived stop");
endmodule

bind qps_slave qps_slave_monitor u_mon (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .tap_select_out(tap_select_out),
  .wiper_float_out(wiper_float_out), .cascade_enable_out(cascade_enable_out),
  .nv_busy_out(nv_busy_out), .incdec_active_out(incdec_active_out)
);

//--- verification/test_qps_slave.sv
// Self-checking bench for the quad pot serial slave
module test_qps_slave;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary type code; it only has to match the instance parameter
  localparam logic [3:0] TYPE_ID = 4'h9;
  localparam logic [3:0] STRAP   = 4'h6;
  localparam logic [7:0] ADDR    = {TYPE_ID, STRAP};
  logic         sys_clk_in = 1'b0;
  logic         rst_in     = 1'b1;
  logic [3:0]   straps     = STRAP;
  logic         ce         = 1'b1;
  logic         k;
  wire          scl;
  wire          sda_pull;
  wire          sda_out;
  wire          sda_oe;
  wire  [255:0] taps;
  wire  [3:0]   flt;
  wire  [3:0]   csc;
  wire          busy;
  wire          inc;
  // Open-drain line with pull-up
  wire          sda = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
  int           num_errors = 0;
  int           cmp_count  = 0;
  int           i;

  always #2.5 sys_clk_in = ~sys_clk_in;

  qps_bus_master m (.scl_out(scl), .sda_pull_out(sda_pull), .sda_in(sda));
  // Short write cycle keeps the run small
  qps_slave #(.DEVICE_TYPE_ID(TYPE_ID), .NV_WRITE_CYCLES(24'h3e8)) dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe),
    .address_select_pins_in(straps), .tap_select_out(taps), .wiper_float_out(flt),
    .cascade_enable_out(csc), .nv_busy_out(busy), .incdec_active_out(inc)
  );

  task automatic chk1(input string n, input logic e, input logic s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic chkv(input string n, input logic [63:0] e, input logic [63:0] s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic tapc(input int p, input int pos);
    chkv("taps", 64'h1 << pos, taps[p*64 +: 64]);
  endtask
  task automatic cmd(input logic [7:0] a, ins, d, input logic n3, ea, ei);
    logic a_k;
    m.start();
    m.wbyte(a, a_k);
    chk1("addr_ack", ea, a_k);
    if (ea) begin
      m.wbyte(ins, a_k);
      chk1("ins_ack", ei, a_k);
      if (n3) begin
        m.wbyte(d, a_k);
        chk1("data_ack", 1'b1, a_k);
      end
    end
    m.stop();
  endtask
  task automatic rd(input logic [7:0] ins, exp);
    logic       r_k;
    logic [7:0] v;
    m.start();
    m.wbyte(ADDR, r_k);
    m.wbyte(ins, r_k);
    m.rbyte(v);
    m.stop();
    chkv("read", 64'(exp), 64'(v));
  endtask
  task automatic poll;
    logic p_k;
    p_k = 1'b0;
    for (int n = 0; n < 40 && !p_k; n++) begin
      m.start();
      m.wbyte(ADDR, p_k);
      m.stop();
    end
    chk1("poll_ack", 1'b1, p_k);
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    waitc(4);
    for (i = 0; i < 4; i++) tapc(i, 0);
    chk1("busy", 1'b0, busy);
    cmd({4'h3, STRAP}, 8'h0, 8'h0, 0, 0, 0);
    cmd({TYPE_ID, ~STRAP}, 8'h0, 8'h0, 0, 0, 0);
    cmd(ADDR, 8'h30, 8'h0, 0, 1, 0);
    cmd(ADDR, 8'ha4, 8'hc5, 1, 1, 1);
    waitc(4);
    tapc(1, 5);
    chk1("float", 1'b1, flt[1]);
    chk1("cascade", 1'b1, csc[1]);
    rd(8'h94, 8'hc5);
    cmd(ADDR, 8'hcb, 8'h2a, 1, 1, 1);
    waitc(6);
    chk1("busy", 1'b1, busy);
    cmd(ADDR, 8'h0, 8'h0, 0, 0, 0);
    poll();
    rd(8'hbb, 8'h2a);
    cmd(ADDR, 8'he5, 8'h0, 0, 1, 1);
    poll();
    rd(8'hb5, 8'hc5);
    cmd(ADDR, 8'hdb, 8'h0, 0, 1, 1);
    tapc(2, 0);
    // Clock enable low freezes the stop-to-wiper countdown
    @(posedge sys_clk_in) ce <= 1'b0;
    waitc(150);
    @(posedge sys_clk_in) ce <= 1'b1;
    waitc(150);
    tapc(2, 0);
    waitc(70);
    tapc(2, 42);
    cmd(ADDR, 8'h82, 8'h0, 0, 1, 1);
    poll();
    rd(8'hb6, 8'hc5);
    cmd(ADDR, 8'h10, 8'h0, 0, 1, 1);
    waitc(220);
    for (i = 0; i < 4; i++) tapc(i, 0);
    chk1("float", 1'b0, flt[1]);
    m.start();
    m.wbyte(ADDR, k);
    m.wbyte(8'h2c, k);
    chk1("ins_ack", 1'b1, k);
    // Two steps down at the floor, then three up
    for (i = 0; i < 5; i++) m.bit_io(i > 1, k);
    tapc(3, 3);
    chk1("incdec", 1'b1, inc);
    m.stop();
    waitc(4);
    chk1("incdec", 1'b0, inc);
    end_sim();
  end

  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
endmodule
